// [verilog/c2alm_pkg.sv]
// Package: constants, register map and carrier types for the channel-2 pin role block
package c2alm_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_LCV_CNT = 4'h3;
  localparam logic [3:0] ADDR_EXZ_CNT = 4'h4;
  localparam logic [3:0] ADDR_ROLE = 4'h5;

  // Control register fields
  localparam int CTRL_BUS_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_FALL_EDGE_BIT = 3;
  localparam int CTRL_LCV_IS_EXZ_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status and mask bits
  localparam int ST_AIS_BIT = 0;
  localparam int ST_LCV_BIT = 1;
  localparam int ST_EXZ_BIT = 2;
  localparam int ST_NEG_BIT = 3;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // Channel operating modes
  localparam logic [1:0] MODE_STS1 = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_DUAL = 2'h2;

  // Role of the pin, one-hot
  typedef enum logic [3:0] {
    ROLE_IDLE = 4'h1,
    ROLE_ALARM = 4'h2,
    ROLE_LCV = 4'h4,
    ROLE_NEG = 4'h8
  } c2alm_role_t;

  // Sampled line symbol, both rails
  typedef struct packed {
    logic valid;
    logic pos;
    logic neg;
  } c2alm_sym_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } c2alm_req_t;

endpackage

// [verilog/c2alm_edge.sv]
// Two-flop synchroniser and edge finder for a slow clock or data pin
`timescale 1ns/10ps
module c2alm_edge (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Pin in
  input wire logic pin_i,
  // Synchronised level and edges
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Stages keep following the pin through reset, so no false edge follows release
  always_ff @(posedge clk_i) begin
    meta_r <= pin_i;
    sync_r <= meta_r;
    prev_r <= sync_r;
  end

  // Edges from the stable stages, blanked while reset settles the pipeline
  assign level_o = sync_r;
  assign rise_o = sync_r & ~prev_r & ~reset_i;
  assign fall_o = ~sync_r & prev_r & ~reset_i;

endmodule

// [verilog/c2alm_top.sv]
// Channel-2 multiplexed input pin: role select, alarm, violation and negative rail
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
// Summary of operation
// - The pin is the add-bus alarm when the telecom bus is enabled, else a mode-set line input.
// - Each add-clock fall that samples the alarm high declares the path alarm defect for the channel.
// - With the bus disabled, the role follows STS-1, single-rail or dual-rail mode.
// - In single-rail mode the pin is the line-code-violation flag from the line interface.
// - The violation input is sampled on the software-chosen edge of the receive line clock.
// - Each sampled violation bumps the violation or excessive-zeros counter.
module c2alm_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Add bus side
  input wire logic add_bus_clock_ch2_i,
  input wire logic add_bus_alarm_in_ch2_i,
  input wire logic [7:0] add_bus_data_ch2_i,
  // Line side
  input wire logic rx_line_clock_ch2_i,
  input wire logic rx_line_pos_rail_ch2_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Decoded outputs
  output logic path_alarm_defect_o,
  output logic [7:0] add_bus_data_o,
  output logic [1:0] rx_symbol_o,
  output logic rx_symbol_valid_o,
  output logic irq_o
);

  c2alm_pkg::c2alm_req_t req;
  c2alm_pkg::c2alm_role_t role_r;
  c2alm_pkg::c2alm_role_t role_nxt;
  c2alm_pkg::c2alm_sym_t sym_r;
  logic [7:0] ctrl_r;
  logic [3:0] status_r;
  logic [3:0] mask_r;
  logic [15:0] lcv_cnt_r;
  logic [15:0] exz_cnt_r;
  logic [15:0] rdata_r;
  logic defect_r;
  logic [7:0] add_data_r;
  logic irq_r;
  logic [7:0] data_m_r;
  logic [7:0] data_s_r;
  logic pos_m_r;
  logic pos_s_r;
  logic lck_rise;
  logic lck_fall;
  logic ack_fall;
  logic pin_level;
  logic line_edge;
  logic [3:0] events;

  // Saturating counter step
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // Clocks and pin all arrive from outside, so each is synchronised
  c2alm_edge u_line_clk (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(rx_line_clock_ch2_i),
    .level_o(),
    .rise_o(lck_rise),
    .fall_o(lck_fall)
  );

  c2alm_edge u_add_clk (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(add_bus_clock_ch2_i),
    .level_o(),
    .rise_o(),
    .fall_o(ack_fall)
  );

  c2alm_edge u_pin (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(add_bus_alarm_in_ch2_i),
    .level_o(pin_level),
    .rise_o(),
    .fall_o()
  );

  // Data and positive rail get their own two stages
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      data_m_r <= 8'h00;
      data_s_r <= 8'h00;
      pos_m_r <= 1'b0;
      pos_s_r <= 1'b0;
    end else begin
      data_m_r <= add_bus_data_ch2_i;
      data_s_r <= data_m_r;
      pos_m_r <= rx_line_pos_rail_ch2_i;
      pos_s_r <= pos_m_r;
    end
  end

  // Configured edge of the line clock
  assign line_edge = ctrl_r[c2alm_pkg::CTRL_FALL_EDGE_BIT] ? lck_fall : lck_rise;

  // Role decode from bus enable and mode
  always_comb begin
    role_nxt = c2alm_pkg::ROLE_IDLE;
    if (ctrl_r[c2alm_pkg::CTRL_BUS_EN_BIT]) begin
      role_nxt = c2alm_pkg::ROLE_ALARM;
    end else begin
      case (ctrl_r[c2alm_pkg::CTRL_MODE_LSB +: 2])
        c2alm_pkg::MODE_SINGLE: role_nxt = c2alm_pkg::ROLE_LCV;
        c2alm_pkg::MODE_DUAL: role_nxt = c2alm_pkg::ROLE_NEG;
        default: role_nxt = c2alm_pkg::ROLE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      role_r <= c2alm_pkg::ROLE_IDLE;
    end else begin
      role_r <= role_nxt;
    end
  end

  // Alarm sampled on add-clock falling edge, like the add data bus
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      defect_r <= 1'b0;
      add_data_r <= 8'h00;
    end else if (role_r == c2alm_pkg::ROLE_ALARM && ack_fall) begin
      defect_r <= pin_level;
      add_data_r <= data_s_r;
    end else if (role_r != c2alm_pkg::ROLE_ALARM) begin
      defect_r <= 1'b0;
    end
  end

  // Dual-rail symbol, both rails on one edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sym_r <= '0;
    end else begin
      sym_r.valid <= (role_r == c2alm_pkg::ROLE_NEG) && line_edge;
      if ((role_r == c2alm_pkg::ROLE_NEG) && line_edge) begin
        sym_r.pos <= pos_s_r;
        sym_r.neg <= pin_level;
      end
    end
  end

  // Event pulses for status; the defect counts on every add-clock fall that samples the alarm high
  always_comb begin
    events = 4'h0;
    events[c2alm_pkg::ST_AIS_BIT] = (role_r == c2alm_pkg::ROLE_ALARM) && ack_fall && pin_level;
    events[c2alm_pkg::ST_LCV_BIT] = (role_r == c2alm_pkg::ROLE_LCV) && line_edge && pin_level
      && !ctrl_r[c2alm_pkg::CTRL_LCV_IS_EXZ_BIT];
    events[c2alm_pkg::ST_EXZ_BIT] = (role_r == c2alm_pkg::ROLE_LCV) && line_edge && pin_level
      && ctrl_r[c2alm_pkg::CTRL_LCV_IS_EXZ_BIT];
    events[c2alm_pkg::ST_NEG_BIT] = (role_r == c2alm_pkg::ROLE_NEG) && line_edge && pin_level;
  end

  // Performance counters; saturate rather than wrap so software sees overflow
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lcv_cnt_r <= c2alm_pkg::CNT_RESET;
      exz_cnt_r <= c2alm_pkg::CNT_RESET;
    end else begin
      if (req.wr && req.addr == c2alm_pkg::ADDR_LCV_CNT) begin
        lcv_cnt_r <= c2alm_pkg::CNT_RESET;
      end else if (events[c2alm_pkg::ST_LCV_BIT]) begin
        lcv_cnt_r <= sat_inc(lcv_cnt_r);
      end
      if (req.wr && req.addr == c2alm_pkg::ADDR_EXZ_CNT) begin
        exz_cnt_r <= c2alm_pkg::CNT_RESET;
      end else if (events[c2alm_pkg::ST_EXZ_BIT]) begin
        exz_cnt_r <= sat_inc(exz_cnt_r);
      end
    end
  end

  // Control and mask writes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_r <= c2alm_pkg::CTRL_RESET;
      mask_r <= c2alm_pkg::MASK_RESET;
    end else if (req.wr) begin
      if (req.addr == c2alm_pkg::ADDR_CTRL) begin
        ctrl_r <= req.wdata[7:0];
      end
      if (req.addr == c2alm_pkg::ADDR_MASK) begin
        mask_r <= req.wdata[3:0];
      end
    end
  end

  // Sticky status, cleared by read; a new event in the read cycle wins
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status_r <= c2alm_pkg::STATUS_RESET;
    end else if (req.rd && req.addr == c2alm_pkg::ADDR_STATUS) begin
      status_r <= events;
    end else begin
      status_r <= status_r | events;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_r <= 16'h0000;
    end else if (req.rd) begin
      case (req.addr)
        c2alm_pkg::ADDR_CTRL: rdata_r <= {8'h00, ctrl_r};
        c2alm_pkg::ADDR_STATUS: rdata_r <= {12'h000, status_r};
        c2alm_pkg::ADDR_MASK: rdata_r <= {12'h000, mask_r};
        c2alm_pkg::ADDR_LCV_CNT: rdata_r <= lcv_cnt_r;
        c2alm_pkg::ADDR_EXZ_CNT: rdata_r <= exz_cnt_r;
        c2alm_pkg::ADDR_ROLE: rdata_r <= {12'h000, role_r};
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  // Level interrupt from registered status and same-cycle events
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |((status_r | events) & mask_r);
    end
  end

  assign reg_rdata_o = rdata_r;
  assign path_alarm_defect_o = defect_r;
  assign add_bus_data_o = add_data_r;
  assign rx_symbol_o = {sym_r.pos, sym_r.neg};
  assign rx_symbol_valid_o = sym_r.valid;
  assign irq_o = irq_r;

endmodule

// [dv/c2alm_assertions.sv]
// Checker for the channel-2 pin role block
`timescale 1ns/10ps
module c2alm_assertions (
  // Clock, reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Pins
  input wire logic add_bus_clock_ch2_i,
  input wire logic add_bus_alarm_in_ch2_i,
  input wire logic rx_line_clock_ch2_i,
  // Register strobes
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  // Results
  input wire logic path_alarm_defect_o,
  input wire logic [1:0] rx_symbol_o,
  input wire logic rx_symbol_valid_o,
  input wire logic irq_o
);
  logic ac_r, lc_r;
  logic [7:0] fall_r, edge_r, hi_r;
  logic acc_w;
  // Any register access, for the interrupt drop check
  assign acc_w = reg_rd_i | reg_wr_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Previous raw clock levels
  always_ff @(posedge clk_i) begin
    ac_r <= add_bus_clock_ch2_i;
    lc_r <= rx_line_clock_ch2_i;
  end
  // Ages since pin events; saturate so idle pins stay quiet
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fall_r <= 8'hFF;
      edge_r <= 8'hFF;
      hi_r <= 8'hFF;
    end else begin
      fall_r <= (ac_r && !add_bus_clock_ch2_i) ? 8'h00 : fall_r + 8'(fall_r != 8'hFF);
      edge_r <= (lc_r != rx_line_clock_ch2_i) ? 8'h00 : edge_r + 8'(edge_r != 8'hFF);
      hi_r <= add_bus_alarm_in_ch2_i ? 8'h00 : hi_r + 8'(hi_r != 8'hFF);
    end
  end
  property p_def_edge; $rose(path_alarm_defect_o) |-> fall_r <= 8'h08; endproperty
  a_def_edge: assert property (p_def_edge) else $error("defect off add fall");
  property p_def_cause; $rose(path_alarm_defect_o) |-> hi_r <= 8'h08; endproperty
  a_def_cause: assert property (p_def_cause) else $error("defect without pin");
  property p_sym_edge; rx_symbol_valid_o |-> edge_r <= 8'h08; endproperty
  a_sym_edge: assert property (p_sym_edge) else $error("symbol off line edge");
  property p_sym_hold; $changed(rx_symbol_o) |-> rx_symbol_valid_o; endproperty
  a_sym_hold: assert property (p_sym_hold) else $error("symbol moved alone");
  property p_sym_gap; rx_symbol_valid_o |=> !rx_symbol_valid_o [*8]; endproperty
  a_sym_gap: assert property (p_sym_gap) else $error("symbol pulse too long");
  property p_irq_fall;
    $fell(irq_o) |-> $past(acc_w, 2) || $past(acc_w, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
  property p_quiet;
    disable iff (1'b0) reset_i |=> !path_alarm_defect_o && !rx_symbol_valid_o && !irq_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output active in reset");
  c_alarm: cover property ($rose(path_alarm_defect_o));
  c_sym: cover property (rx_symbol_valid_o);
  c_irq: cover property ($fell(irq_o));
endmodule

bind c2alm_top c2alm_assertions c2alm_assertions_i (.clk_i, .reset_i, .add_bus_clock_ch2_i,
  .add_bus_alarm_in_ch2_i, .rx_line_clock_ch2_i, .reg_wr_i, .reg_rd_i, .path_alarm_defect_o,
  .rx_symbol_o, .rx_symbol_valid_o, .irq_o);

// [dv/c2alm_far_model.sv]
// Far side model: add-bus logic and line interface for channel 2
`timescale 1ns/10ps
module c2alm_far_model (
  // Role from the bench
  input wire logic bus_en_i,
  input wire logic [1:0] mode_i,
  input wire logic fall_i,
  // Pins toward the block
  output logic add_clk_o,
  output logic alarm_o,
  output logic [7:0] data_o,
  output logic line_clk_o,
  output logic pos_o,
  output logic pin_o
);
  logic bit_r;
  // Free clocks, every edge landing on a falling edge of the system clock
  initial begin
    add_clk_o = 1'b1;
    line_clk_o = 1'b0;
    alarm_o = 1'b0;
    data_o = 8'h00;
    bit_r = 1'b0;
    pos_o = 1'b0;
  end
  always #48 add_clk_o = ~add_clk_o;
  always #80 line_clk_o = ~line_clk_o;
  // Alarm pulses with its byte, launched half a clock before the sampling fall
  always @(posedge add_clk_o) begin
    alarm_o <= bus_en_i & 1'($urandom);
    data_o <= 8'($urandom);
  end
  // Line data moves only on the edge the block does not sample
  always @(line_clk_o) begin
    if (line_clk_o == fall_i) begin
      bit_r <= 1'($urandom);
      pos_o <= 1'($urandom);
    end
  end
  // Alarm with the bus enabled; else violation or negative rail in single or dual mode, low otherwise
  assign pin_o = bus_en_i ? alarm_o : (mode_i == 2'h1 || mode_i == 2'h2) & bit_r;
endmodule

// [dv/c2alm_top_tb_top.sv]
// Self-checking bench for the channel-2 pin role block
`timescale 1ns/10ps
module c2alm_top_tb_top;
  logic clk_i, reset_i, wr, rd, aclk, lclk, pos, pin, dfct, sval, irq, seen, cnt_on;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  logic [7:0] ctrl, adata, data;
  logic [8:0] dv;
  logic [1:0] sym;
  logic [1:0] symq[$];
  int num_errors, num_checks, cyc, cnt, k;
  c2alm_top c2alm_top_i (.clk_i, .reset_i, .add_bus_clock_ch2_i(aclk),
    .add_bus_alarm_in_ch2_i(pin), .add_bus_data_ch2_i(data), .rx_line_clock_ch2_i(lclk),
    .rx_line_pos_rail_ch2_i(pos), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .path_alarm_defect_o(dfct), .add_bus_data_o(adata),
    .rx_symbol_o(sym), .rx_symbol_valid_o(sval), .irq_o(irq));
  c2alm_far_model c2alm_far_model_i (.bus_en_i(ctrl[0]), .mode_i(ctrl[2:1]),
    .fall_i(ctrl[3]), .add_clk_o(aclk), .alarm_o(), .data_o(data), .line_clk_o(lclk),
    .pos_o(pos), .pin_o(pin));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] e, input bit c = 1'b1);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    if (c) chk(rdata, e);
  endtask
  // Reconfigure well clear of a pin-clock edge, so no sample is in flight
  task automatic cfg(input logic [7:0] c, input bit a = 1'b0);
    if (a) @(negedge aclk);
    else @(lclk);
    repeat (10) @(posedge clk_i);
    wreg(c2alm_pkg::ADDR_CTRL, {8'h00, c});
    ctrl <= c;
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Reference model: violation count and negative-rail symbols per sampled edge
  always @(lclk) begin
    if (lclk != ctrl[3] && !ctrl[0]) begin
      if (cnt_on && ctrl[2:1] == 2'h1 && pin) cnt++;
      if (ctrl[2:1] == 2'h2) symq.push_back({pos, pin});
    end
  end
  always @(posedge clk_i) begin
    if (sval) chk(16'(sym), 16'(symq.pop_front()));
  end
  always @(negedge aclk) begin
    if (ctrl[0] && pin) seen = 1'b1;
  end
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    reset_i = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    ctrl = 8'h00;
    seen = 1'b0;
    cnt_on = 1'b0;
    k = $urandom(32'hD7D5);
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    for (k = 0; k < 6; k++) rchk(k[3:0], k == 5 ? 16'h0001 : 16'h0000);
    rchk(4'hF, 16'h0000);
    $display("reset test done");
    for (k = 0; k < 8; k++) begin
      cfg(8'(k));
      rchk(c2alm_pkg::ADDR_ROLE, k[0] ? 16'h0002 : 16'h1841 >> 4 * k[2:1] & 16'h000F);
    end
    $display("role test done");
    for (k = 0; k < 4; k++) begin
      cfg({3'h0, k[1:0], 3'h2});
      wreg(c2alm_pkg::ADDR_LCV_CNT, 16'h0000);
      wreg(c2alm_pkg::ADDR_EXZ_CNT, 16'h0000);
      cnt = 0;
      cnt_on = 1'b1;
      repeat (16) @(lclk);
      repeat (10) @(posedge clk_i);
      cnt_on = 1'b0;
      rchk(c2alm_pkg::ADDR_LCV_CNT, k[1] ? 16'h0000 : 16'(cnt));
      rchk(c2alm_pkg::ADDR_EXZ_CNT, k[1] ? 16'(cnt) : 16'h0000);
    end
    $display("violation test done");
    for (k = 0; k < 2; k++) begin
      cfg({4'h0, k[0], 3'h4});
      repeat (16) @(lclk);
    end
    cfg(8'h00);
    chk(16'(symq.size()), 16'h0000);
    $display("dual rail test done");
    rchk(c2alm_pkg::ADDR_STATUS, 16'h0000, 1'b0);
    cfg(8'h01, 1'b1);
    seen = 1'b0;
    repeat (8) begin
      @(negedge aclk);
      dv = {pin, data};
      repeat (10) @(posedge clk_i);
      chk(16'(dfct), 16'(dv[8]));
      chk(16'(adata), 16'(dv[7:0]));
    end
    cfg(8'h00, 1'b1);
    chk(16'(irq), 16'h0000);
    wreg(c2alm_pkg::ADDR_MASK, 16'h000F);
    repeat (3) @(posedge clk_i);
    chk(16'(irq), 16'(seen));
    rchk(c2alm_pkg::ADDR_STATUS, 16'(seen));
    repeat (3) @(posedge clk_i);
    chk(16'(irq), 16'h0000);
    $display("alarm test done");
    stop_test();
  end
endmodule
